// ==== rtl/tpw_pkg.sv ====
// package: register map, field layout, modes, reset values and bus carriers of the pwm timer
package tpw_pkg;
   localparam int unsigned ADDR_W        = 8;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_CMP_A     = 8'h04;
   localparam logic [7:0]  OFS_CMP_B     = 8'h08;
   localparam logic [7:0]  OFS_CAP_TOP   = 8'h0C;
   localparam logic [7:0]  OFS_COUNT     = 8'h10;
   localparam logic [7:0]  OFS_STATUS    = 8'h14;
   // control field positions
   localparam int          CTRL_MODE_LSB = 0;
   localparam int          CTRL_ACT_LSB  = 4;
   localparam int          CTRL_PSC_LSB  = 8;
   localparam int          CTRL_DIR_LSB  = 11;
   localparam logic [15:0] CTRL_WR_MASK  = 16'h1FFF;
   // status flag positions
   localparam int          ST_OVF        = 0;
   localparam int          ST_MATCH_LSB  = 1;
   localparam int          ST_CAP        = 3;
   // reset values
   localparam logic [15:0] CTRL_RST      = 16'h0000;
   localparam logic [15:0] VAL_RST       = 16'h0000;
   localparam logic [3:0]  FLAGS_RST     = 4'h0;
   // waveform modes
   localparam logic [3:0]  MODE_PC8      = 4'h1;
   localparam logic [3:0]  MODE_PC9      = 4'h2;
   localparam logic [3:0]  MODE_PC10     = 4'h3;
   localparam logic [3:0]  MODE_FAST8    = 4'h5;
   localparam logic [3:0]  MODE_FAST9    = 4'h6;
   localparam logic [3:0]  MODE_FAST10   = 4'h7;
   localparam logic [3:0]  MODE_PC_CAP   = 4'hA;
   localparam logic [3:0]  MODE_PC_CMP   = 4'hB;
   localparam logic [3:0]  MODE_FAST_CAP = 4'hE;
   localparam logic [3:0]  MODE_FAST_CMP = 4'hF;
   // compare output actions
   localparam logic [1:0]  ACT_OFF       = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE    = 2'h1;
   localparam logic [1:0]  ACT_NONINV    = 2'h2;
   localparam logic [1:0]  ACT_INV       = 2'h3;
   // fixed top values and the smallest register top
   localparam logic [15:0] TOP_8BIT      = 16'h00FF;
   localparam logic [15:0] TOP_9BIT      = 16'h01FF;
   localparam logic [15:0] TOP_10BIT     = 16'h03FF;
   localparam logic [15:0] TOP_MIN       = 16'h0003;
   // prescaler divide-by minus one, selected by codes 1 to 5
   localparam logic [9:0]  PSC_DIV1_M1   = 10'h000;
   localparam logic [9:0]  PSC_DIV8_M1   = 10'h007;
   localparam logic [9:0]  PSC_DIV64_M1  = 10'h03F;
   localparam logic [9:0]  PSC_DIV256_M1 = 10'h0FF;
   localparam logic [9:0]  PSC_DIV1K_M1  = 10'h3FF;
   // bus responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } tpw_axi_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tpw_axi_rsp_s;

   typedef struct packed {
      logic              en;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       data;
      logic [3:0]        strb;
   } tpw_regwr_s;
endpackage : tpw_pkg

// ==== rtl/tpw_presc.sv ====
// prescaler: timer tick from the i/o clock divided by 1, 8, 64, 256 or 1024
module tpw_presc (
   input  logic       clk_in,
   input  logic       rst_n_in,
   input  logic [2:0] sel_in,
   output logic       tick_out
);
   import tpw_pkg::*;

   typedef struct packed {
      logic [9:0] cnt;
   } tpw_presc_s;

   tpw_presc_s s_reg;
   tpw_presc_s s_next;
   logic [9:0] div_m1;
   logic       run;

   // divider choice; codes 0, 6 and 7 stop the timer
   always_comb begin
      run    = 1'b1;
      div_m1 = PSC_DIV1_M1;
      case (sel_in)
         3'h1: div_m1 = PSC_DIV1_M1;
         3'h2: div_m1 = PSC_DIV8_M1;
         3'h3: div_m1 = PSC_DIV64_M1;
         3'h4: div_m1 = PSC_DIV256_M1;
         3'h5: div_m1 = PSC_DIV1K_M1;
         default: run = 1'b0;
      endcase
   end

   assign tick_out = run && (s_reg.cnt >= div_m1); // no long stall after a shorter divider

   // divide counter restarts on each tick
   always_comb begin
      s_next     = s_reg;
      s_next.cnt = (!run || tick_out) ? 10'h000 : 10'(s_reg.cnt + 10'h001);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : tpw_presc

// ==== rtl/tpw_axil.sv ====
// axi4-lite slave: takes address and data in either order, one write and one read at a time
module tpw_axil (
   input  logic                  clk_in,
   input  logic                  rst_n_in,
   input  tpw_pkg::tpw_axi_req_s axi_req_in,
   output tpw_pkg::tpw_axi_rsp_s axi_rsp_out,
   output tpw_pkg::tpw_regwr_s   wr_out,
   input  logic                  wr_err_in,
   output logic [7:0]            rd_addr_out,
   input  logic [31:0]           rd_data_in,
   input  logic                  rd_err_in
);
   import tpw_pkg::*;

   typedef struct packed {
      logic        aw_held;
      logic        w_held;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tpw_axil_s;

   tpw_axil_s s_reg;
   tpw_axil_s s_next;

   // ready and response outputs straight from state
   always_comb begin
      axi_rsp_out.awready = !s_reg.aw_held && !s_reg.bvalid;
      axi_rsp_out.wready  = !s_reg.w_held && !s_reg.bvalid;
      axi_rsp_out.bvalid  = s_reg.bvalid;
      axi_rsp_out.bresp   = s_reg.bresp;
      axi_rsp_out.arready = !s_reg.rvalid;
      axi_rsp_out.rvalid  = s_reg.rvalid;
      axi_rsp_out.rdata   = s_reg.rdata;
      axi_rsp_out.rresp   = s_reg.rresp;
      wr_out.en           = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
      wr_out.addr         = s_reg.awaddr;
      wr_out.data         = s_reg.wdata;
      wr_out.strb         = s_reg.wstrb;
      rd_addr_out         = axi_req_in.araddr;
   end

   // channel handshakes
   always_comb begin
      s_next = s_reg;
      if (axi_req_in.awvalid && axi_rsp_out.awready) begin
         s_next.aw_held = 1'b1;
         s_next.awaddr  = axi_req_in.awaddr;
      end
      if (axi_req_in.wvalid && axi_rsp_out.wready) begin
         s_next.w_held = 1'b1;
         s_next.wdata  = axi_req_in.wdata;
         s_next.wstrb  = axi_req_in.wstrb;
      end
      if (wr_out.en) begin
         s_next.aw_held = 1'b0;
         s_next.w_held  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = wr_err_in ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_reg.bvalid && axi_req_in.bready) begin
         s_next.bvalid = 1'b0;
      end
      if (axi_req_in.arvalid && axi_rsp_out.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = rd_data_in;
         s_next.rresp  = rd_err_in ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_reg.rvalid && axi_req_in.rready) begin
         s_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : tpw_axil

// ==== rtl/tpw_pwm_top.sv ====
// pwm timer top: 16-bit counter with fast and phase correct pwm, two compare channels
//
// Contract
// - Modes 5, 6, 7, 14, 15 count up from zero to top, then restart.
// - Fast non-inverting clears on match, sets at zero; inverting does the reverse.
// - Action two gives non-inverted output, action three inverted output.
// - Fast top is 0xFF, 0x1FF, 0x3FF, capture or compare A; clear after top.
// - Register tops from 0x0003 to 0xFFFF work; software keeps top at least 0x0003.
// - A channel's match flag sets whenever the count equals its compare value; the code sets it only on a tick in a fast or phase correct mode.
// - Fast overflow flag sets at top; the defining register's flag sets with it.
// - With a fixed top, compare writes clear the bits above the resolution.
// - Capture top is unbuffered; written below count, counter wraps through 0xFFFF.
// - Fast compare writes go to a buffer loaded into the active value at top.
// - A pin shows the output state only when its direction bit selects output.
// - Tick is the clock divided by 1, 8, 64, 256 or 1024.
// - Fast compare zero gives a one-tick spike; compare equal top a constant level.
// - Action one on channel A in mode 15 toggles on each match.
// - Modes 1, 2, 3, 10, 11 count up to top and back down to zero.
// - Phase correct non-inverting clears on up-count match, sets on down-count match.
// - Phase correct top is fixed, capture or compare A; top holds one tick.
// - Phase correct overflow flag sets each time the count reaches zero; the code sets it only on reaching zero counting down.
// - Phase correct buffers load at top; the defining register's flag sets there.
// - Reset clears the output states to zero.
// - Action zero leaves the state alone; nonzero actions take over the pin.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
module tpw_pwm_top (
   input  logic                  clk_in,
   input  logic                  rst_n_in,
   input  tpw_pkg::tpw_axi_req_s axi_req_in,
   output tpw_pkg::tpw_axi_rsp_s axi_rsp_out,
   input  logic [1:0]            port_data_in,
   output logic [1:0]            pin_out,
   output logic [1:0]            pin_oe_out
);
   import tpw_pkg::*;

   typedef struct packed {
      logic [15:0]      ctrl;
      logic [1:0][15:0] cmp_buf;
      logic [1:0][15:0] cmp;
      logic [15:0]      cap_top;
      logic [15:0]      cnt;
      logic             count_down;
      logic [1:0]       out_state;
      logic [3:0]       flags;
   } tpw_core_s;

   localparam tpw_core_s CORE_RST = '{ctrl: CTRL_RST, cmp_buf: {VAL_RST, VAL_RST}, cmp: {VAL_RST, VAL_RST},
                                      cap_top: VAL_RST, cnt: VAL_RST, count_down: 1'b0,
                                      out_state: 2'h0, flags: FLAGS_RST};

   tpw_core_s   s_reg;
   tpw_core_s   s_next;
   tpw_regwr_s  wr;
   logic        wr_err;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;
   logic        tick;
   logic [3:0]  mode;
   logic [1:0]  act [2];
   logic [1:0]  dir;
   logic        is_fast;
   logic        is_pc;
   logic        top_fixed;
   logic        top_from_cap;
   logic        top_from_cmp;
   logic [15:0] top;
   logic        at_top;
   logic [1:0]  hit;
   logic [31:0] wval;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave and prescaler

   tpw_axil u_axil (
      .clk_in      (clk_in),
      .rst_n_in    (rst_n_in),
      .axi_req_in  (axi_req_in),
      .axi_rsp_out (axi_rsp_out),
      .wr_out      (wr),
      .wr_err_in   (wr_err),
      .rd_addr_out (rd_addr),
      .rd_data_in  (rd_data),
      .rd_err_in   (rd_err)
   );

   tpw_presc u_presc (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .sel_in   (s_reg.ctrl[CTRL_PSC_LSB +: 3]),
      .tick_out (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // mode decode and top selection

   assign mode = s_reg.ctrl[CTRL_MODE_LSB +: 4];

   always_comb begin
      is_fast      = 1'b0;
      is_pc        = 1'b0;
      top_fixed    = 1'b0;
      top_from_cap = 1'b0;
      top_from_cmp = 1'b0;
      top          = s_reg.cmp[0];
      case (mode)
         MODE_FAST8, MODE_PC8: begin
            top       = TOP_8BIT;
            top_fixed = 1'b1;
         end
         MODE_FAST9, MODE_PC9: begin
            top       = TOP_9BIT;
            top_fixed = 1'b1;
         end
         MODE_FAST10, MODE_PC10: begin
            top       = TOP_10BIT;
            top_fixed = 1'b1;
         end
         MODE_FAST_CAP, MODE_PC_CAP: begin
            top          = s_reg.cap_top; // unbuffered
            top_from_cap = 1'b1;
         end
         MODE_FAST_CMP, MODE_PC_CMP: begin
            top          = s_reg.cmp[0];
            top_from_cmp = 1'b1;
         end
         default: top = s_reg.cmp[0];
      endcase
      is_fast = (mode == MODE_FAST8) || (mode == MODE_FAST9) || (mode == MODE_FAST10) ||
                (mode == MODE_FAST_CAP) || (mode == MODE_FAST_CMP);
      is_pc   = (mode == MODE_PC8) || (mode == MODE_PC9) || (mode == MODE_PC10) ||
                (mode == MODE_PC_CAP) || (mode == MODE_PC_CMP);
   end

   assign at_top = (s_reg.cnt == top);

   ////////////////////////////////////////////////////////////////////////////
   // per-channel compare, action and pin drive

   genvar g;
   for (g = 0; g < 2; g++) begin : g_ch
      assign act[g]        = s_reg.ctrl[CTRL_ACT_LSB + 2*g +: 2];
      assign dir[g]        = s_reg.ctrl[CTRL_DIR_LSB + g];
      assign hit[g]        = (s_reg.cnt == s_reg.cmp[g]);
      assign pin_out[g]    = (act[g] != ACT_OFF) ? s_reg.out_state[g] : port_data_in[g];
      assign pin_oe_out[g] = dir[g];
   end

   ////////////////////////////////////////////////////////////////////////////
   // register decode

   // write merge by byte strobes, error on unmapped offsets
   always_comb begin
      wval = 32'h0000_0000;
      case (wr.addr)
         OFS_CTRL:    wval = {16'h0000, s_reg.ctrl};
         OFS_CMP_A:   wval = {16'h0000, s_reg.cmp_buf[0]};
         OFS_CMP_B:   wval = {16'h0000, s_reg.cmp_buf[1]};
         OFS_CAP_TOP: wval = {16'h0000, s_reg.cap_top};
         default:     wval = 32'h0000_0000;
      endcase
      for (int b = 0; b < 4; b++) begin
         if (wr.strb[b]) begin
            wval[8*b +: 8] = wr.data[8*b +: 8];
         end
      end
      wr_err = !((wr.addr == OFS_CTRL) || (wr.addr == OFS_CMP_A) || (wr.addr == OFS_CMP_B) ||
                 (wr.addr == OFS_CAP_TOP) || (wr.addr == OFS_COUNT) || (wr.addr == OFS_STATUS));
   end

   // read mux, upper bits read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (rd_addr)
         OFS_CTRL:    rd_data = {16'h0000, s_reg.ctrl};
         OFS_CMP_A:   rd_data = {16'h0000, s_reg.cmp_buf[0]};
         OFS_CMP_B:   rd_data = {16'h0000, s_reg.cmp_buf[1]};
         OFS_CAP_TOP: rd_data = {16'h0000, s_reg.cap_top};
         OFS_COUNT:   rd_data = {16'h0000, s_reg.cnt};
         OFS_STATUS:  rd_data = {28'h000_0000, s_reg.flags};
         default:     rd_err  = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter, compare buffers, flags and output states

   always_comb begin
      s_next = s_reg;
      // software writes
      if (wr.en) begin
         case (wr.addr)
            OFS_CTRL:    s_next.ctrl       = wval[15:0] & CTRL_WR_MASK;
            OFS_CMP_A:   s_next.cmp_buf[0] = top_fixed ? (wval[15:0] & top) : wval[15:0];
            OFS_CMP_B:   s_next.cmp_buf[1] = top_fixed ? (wval[15:0] & top) : wval[15:0];
            OFS_CAP_TOP: s_next.cap_top    = wval[15:0];
            OFS_STATUS:  s_next.flags      = s_reg.flags & ~(wval[3:0] & wr.data[3:0]);
            default:     s_next.ctrl       = s_reg.ctrl;
         endcase
      end
      // outside the pwm families the compare values follow the buffers at once
      if (!is_fast && !is_pc) begin
         s_next.cmp = s_reg.cmp_buf;
      end
      if (tick && is_fast) begin
         s_next.count_down = 1'b0;
         if (at_top) begin
            s_next.cnt              = 16'h0000;
            s_next.cmp              = s_reg.cmp_buf;
            s_next.flags[ST_OVF]    = 1'b1;
            s_next.flags[ST_CAP]    = s_next.flags[ST_CAP] | top_from_cap;
         end else begin
            s_next.cnt = 16'(s_reg.cnt + 16'h0001); // full 16-bit range, wraps through 0xFFFF
         end
      end else if (tick && is_pc) begin
         if (!s_reg.count_down) begin
            if (at_top) begin
               s_next.cnt           = 16'(top - 16'h0001);
               s_next.count_down    = 1'b1;
               s_next.cmp           = s_reg.cmp_buf;
               s_next.flags[ST_CAP] = s_next.flags[ST_CAP] | top_from_cap;
            end else begin
               s_next.cnt = 16'(s_reg.cnt + 16'h0001);
            end
         end else if (s_reg.cnt == 16'h0000) begin
            s_next.cnt           = 16'h0001;
            s_next.count_down    = 1'b0;
            s_next.flags[ST_OVF] = 1'b1;
         end else begin
            s_next.cnt = 16'(s_reg.cnt - 16'h0001);
         end
      end
      if (tick && (is_fast || is_pc)) begin
         // match flags set after the clear, so an event wins over software
         s_next.flags[ST_MATCH_LSB +: 2] = s_next.flags[ST_MATCH_LSB +: 2] | hit;
         for (int ch = 0; ch < 2; ch++) begin
            if ((ch == 0) && (act[ch] == ACT_TOGGLE) && top_from_cmp) begin
               if (hit[ch]) begin
                  s_next.out_state[ch] = !s_reg.out_state[ch];
               end
            end else if (act[ch][1]) begin
               if (is_fast) begin
                  if (at_top) begin
                     s_next.out_state[ch] = !act[ch][0]; // bottom action wins
                  end else if (hit[ch]) begin
                     s_next.out_state[ch] = act[ch][0];
                  end
               end else if (hit[ch]) begin
                  if (at_top && !s_reg.count_down) begin
                     s_next.out_state[ch] = !act[ch][0]; // compare at top holds the set level
                  end else if (s_reg.cnt == 16'h0000) begin
                     s_next.out_state[ch] = act[ch][0]; // compare at zero holds the clear level
                  end else begin
                     s_next.out_state[ch] = s_reg.count_down ^ act[ch][0];
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_reg <= CORE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_fast_inc;
      tick && is_fast && !at_top |=> s_reg.cnt == 16'($past(s_reg.cnt) + 16'h0001);
   endproperty
   a_fast_inc: assert property (p_fast_inc) else $error("fast count did not step up");

   property p_fast_wrap;
      tick && is_fast && at_top |=> s_reg.cnt == 16'h0000 && s_reg.flags[ST_OVF];
   endproperty
   a_fast_wrap: assert property (p_fast_wrap) else $error("fast count did not clear at top");

   property p_fast_cap_flag;
      tick && (mode == MODE_FAST_CAP) && at_top |=> s_reg.flags[ST_CAP] && s_reg.flags[ST_OVF];
   endproperty
   a_fast_cap_flag: assert property (p_fast_cap_flag) else $error("capture flag not set with overflow");

   property p_buf_load;
      tick && (is_fast || (is_pc && !s_reg.count_down)) && at_top |=> s_reg.cmp == $past(s_reg.cmp_buf);
   endproperty
   a_buf_load: assert property (p_buf_load) else $error("compare buffer not loaded at top");

   property p_fast_bottom_set;
      tick && is_fast && at_top && (act[0] == ACT_NONINV) |=> s_reg.out_state[0];
   endproperty
   a_fast_bottom_set: assert property (p_fast_bottom_set) else $error("output not set at bottom");

   property p_match_flag;
      tick && (is_fast || is_pc) && hit[1] |=> s_reg.flags[ST_MATCH_LSB + 1];
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match flag missed");

   property p_pc_turn;
      tick && is_pc && !s_reg.count_down && at_top |=> s_reg.count_down ##0 s_reg.cnt == 16'($past(top) - 16'h0001);
   endproperty
   a_pc_turn: assert property (p_pc_turn) else $error("phase correct did not turn at top");

   property p_pc_ovf;
      tick && is_pc && s_reg.count_down && (s_reg.cnt == 16'h0000) |=> s_reg.flags[ST_OVF] && !s_reg.count_down;
   endproperty
   a_pc_ovf: assert property (p_pc_ovf) else $error("overflow not set at bottom");

   property p_idle_hold;
      !tick && !wr.en |=> $stable(s_reg.cnt) && $stable(s_reg.out_state);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("counter moved without a tick");

   property p_pin_hidden;
      !dir[0] |-> !pin_oe_out[0];
   endproperty
   a_pin_hidden: assert property (p_pin_hidden) else $error("pin driven while set as input");

   property p_mask;
      wr.en && (wr.addr == OFS_CMP_B) && top_fixed |=> (s_reg.cmp_buf[1] & ~$past(top)) == 16'h0000;
   endproperty
   a_mask: assert property (p_mask) else $error("compare bits above resolution kept");

   property p_fast_match_clr;
      tick && is_fast && !at_top && hit[0] && (act[0] == ACT_NONINV) |=> !s_reg.out_state[0];
   endproperty
   a_fast_match_clr: assert property (p_fast_match_clr) else $error("output not cleared on match");

   property p_pc_down_set;
      tick && is_pc && s_reg.count_down && hit[0] && (s_reg.cnt != 16'h0000) && (act[0] == ACT_NONINV)
         |=> s_reg.out_state[0];
   endproperty
   a_pc_down_set: assert property (p_pc_down_set) else $error("output not set on down match");

   property p_toggle;
      tick && top_from_cmp && (act[0] == ACT_TOGGLE) && hit[0]
         |=> s_reg.out_state[0] != $past(s_reg.out_state[0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("channel a did not toggle on match");
endmodule : tpw_pwm_top

// ==== verif/tb_top.sv ====
// testbench: pwm timer register access, count ranges, flags and pin levels
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import tpw_pkg::*;

   logic         clk_in       = 1'b0;
   logic         rst_n_in     = 1'b0;
   tpw_axi_req_s req          = '0;
   tpw_axi_rsp_s rsp;
   logic [1:0]   port_data_in = 2'b10;
   logic [1:0]   pin_out;
   logic [1:0]   pin_oe_out;
   int           err_total    = 0;
   int           n_compared   = 0;
   logic [31:0]  rdat;
   logic [1:0]   resp;
   logic [3:0]   fmode [3]    = '{MODE_FAST8, MODE_FAST9, MODE_FAST10};
   logic [15:0]  ftop [3]     = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};
   logic [3:0]   rmode [2]    = '{MODE_FAST_CAP, MODE_PC_CAP};
   logic [1:0]   acts [2]     = '{ACT_NONINV, ACT_INV};

   // design under test
   tpw_pwm_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .axi_req_in(req), .axi_rsp_out(rsp),
      .port_data_in(port_data_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out));

   // 40 mhz clock
   always #12.5 clk_in = ~clk_in;

   // compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // bus write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_t, w_t, b_t;
      @(posedge clk_in);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do begin
         @(negedge clk_in);
         aw_t = req.awvalid & rsp.awready;
         w_t  = req.wvalid & rsp.wready;
         b_t  = rsp.bvalid;
         resp = rsp.bresp;
         @(posedge clk_in);
         if (aw_t) req.awvalid <= 1'b0;
         if (w_t) req.wvalid <= 1'b0;
      end while (!b_t);
      req.bready <= 1'b0;
   endtask : wr

   // bus read: data and response taken at the edge that sees rvalid
   task automatic rd(input logic [7:0] a);
      logic ar_t, r_t;
      @(posedge clk_in);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do begin
         @(negedge clk_in);
         ar_t = req.arvalid & rsp.arready;
         r_t  = rsp.rvalid;
         rdat = rsp.rdata;
         resp = rsp.rresp;
         @(posedge clk_in);
         if (ar_t) req.arvalid <= 1'b0;
      end while (!r_t);
      req.rready <= 1'b0;
   endtask : rd

   // control word: direction a out, prescaler code, action on channel a only
   function automatic logic [31:0] ctrl(input logic [3:0] m, input logic [1:0] act, input logic [2:0] ps);
      return {19'h0, 2'b01, ps, 2'h0, act, m};
   endfunction : ctrl

   // channel a pin must hold one level over sixteen clocks
   task automatic hold_chk(input logic lvl);
      repeat (16) begin
         @(negedge clk_in);
         chk({31'h0, pin_out[0]}, {31'h0, lvl});
      end
   endtask : hold_chk

   // channel a pin: high samples and level changes over n clocks
   task automatic duty_chk(input int n, input int hi, input int ed);
      logic [31:0] h = '0;
      logic [31:0] e = '0;
      logic        prev;
      @(negedge clk_in);
      prev = pin_out[0];
      repeat (n) begin
         @(negedge clk_in);
         h = h + 32'(pin_out[0]);
         e = e + 32'(pin_out[0] != prev);
         prev = pin_out[0];
      end
      chk(h, hi);
      chk(e, ed);
   endtask : duty_chk

   // verdict
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // main sequence
   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(OFS_CTRL);
      chk(rdat, 32'h0);
      rd(OFS_STATUS);
      chk(rdat, 32'h0);
      chk({30'h0, pin_oe_out}, 32'h0);
      chk({30'h0, pin_out}, {30'h0, port_data_in});
      rd(8'h18);
      chk({rdat[29:0], resp}, {30'h0, RESP_SLVERR});
      wr(8'h18, 32'hFFFF);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      foreach (fmode[i]) begin
         wr(OFS_CTRL, {28'h0, fmode[i]});
         wr(OFS_CMP_A, 32'h1234);
         rd(OFS_CMP_A);
         chk(rdat, {16'h0, 16'h1234 & ftop[i]});
      end
      wr(OFS_CMP_A, 32'h80);
      wr(OFS_CTRL, ctrl(MODE_FAST8, ACT_NONINV, 3'h1));
      wr(OFS_STATUS, 32'hF);
      repeat (258) @(posedge clk_in);
      rd(OFS_STATUS);
      chk({31'h0, rdat[ST_OVF]}, 32'h1);
      rd(OFS_COUNT);
      chk({31'h0, rdat <= 32'h00FF}, 32'h1);
      // second reset so the small top is written below no running count
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      wr(OFS_CAP_TOP, 32'h3);
      wr(OFS_CMP_A, 32'h3);
      foreach (rmode[i]) foreach (acts[j]) begin
         wr(OFS_CTRL, ctrl(rmode[i], acts[j], 3'h1));
         wr(OFS_STATUS, 32'hF);
         repeat (12) @(posedge clk_in);
         rd(OFS_STATUS);
         chk(rdat & 32'h9, 32'h9);
         rd(OFS_COUNT);
         chk({31'h0, rdat <= 32'h3}, 32'h1);
         hold_chk(acts[j] == ACT_NONINV);
         chk({30'h0, pin_oe_out}, 32'h1);
         chk({31'h0, pin_out[1]}, {31'h0, port_data_in[1]});
      end
      // compare zero at divide by eight: one tick of four high, 8 of 32 clocks
      wr(OFS_CMP_A, 32'h0);
      wr(OFS_CTRL, ctrl(MODE_FAST_CAP, ACT_NONINV, 3'h2));
      repeat (64) @(posedge clk_in);
      duty_chk(64, 16, 4);
      // phase correct at compare one: high on zero down and one up, 2 of 6 ticks
      wr(OFS_CMP_A, 32'h1);
      wr(OFS_CTRL, ctrl(MODE_PC_CAP, ACT_NONINV, 3'h1));
      repeat (24) @(posedge clk_in);
      duty_chk(12, 4, 4);
      // toggle with compare a as top; the new value loads at a phase correct top first
      wr(OFS_CMP_A, 32'h3);
      repeat (8) @(posedge clk_in);
      wr(OFS_CTRL, ctrl(MODE_FAST_CMP, ACT_TOGGLE, 3'h1));
      repeat (16) @(posedge clk_in);
      duty_chk(16, 8, 4);
      conclude();
   end

   // watchdog against a hung handshake
   initial begin
      #500000;
      err_total++;
      conclude();
   end
endmodule : tb_top
